/* File: common/nhc_pkg.sv */
`default_nettype none
package nhc_pkg;
   localparam logic [7:0] CMD_READ_SETUP = 8'h00;
   localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
   localparam logic [7:0] CMD_COL_SETUP = 8'h05;
   localparam logic [7:0] CMD_COL_CONFIRM = 8'hE0;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] ID_ADDR_DEVICE = 8'h00;
   localparam logic [7:0] ID_ADDR_SIGNATURE = 8'h20;
   localparam logic [3:0] ID_DEVICE_BYTES = 4'h5;
   localparam logic [3:0] ID_SIGNATURE_BYTES = 4'h4;
   localparam int COL_LOW_W = 8;
   localparam int COL_HIGH_W = 4;
   localparam int ROW_W = 16;
   localparam logic [3:0] BUS_HIGH_NIBBLE_LOW = 4'h0;
   localparam int CLK_PERIOD_NS = 100;
   localparam int STROBE_LOW_NS = 100;
   localparam int STROBE_HIGH_NS = 100;
   localparam int STROBE_LOW_CYC =
      (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_HIGH_CYC =
      (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_STAGES = 2;
   localparam logic [3:0] OP_PAGE_READ = 4'h0;
   localparam logic [3:0] OP_COL_MOVE = 4'h1;
   localparam logic [3:0] OP_READ_BYTES = 4'h2;
   localparam logic [3:0] OP_READ_ID = 4'h3;
   localparam logic [3:0] OP_SIGNATURE = 4'h4;
   localparam logic [3:0] OP_STATUS = 4'h5;
   localparam logic [3:0] OP_FIRST_READ = 4'h6;
   typedef enum logic [2:0]
   {
      BUS_IDLE = 3'b000,
      BUS_WE_LOW = 3'b001,
      BUS_WE_HIGH = 3'b010,
      BUS_RE_LOW = 3'b011,
      BUS_RE_HIGH = 3'b100
   } nhc_bus_state_t;
endpackage : nhc_pkg
`default_nettype wire

/* File: common/nhc_stream_if.sv */
`default_nettype none
interface nhc_stream_if;
   logic valid;
   logic ready;
   logic [7:0] data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface : nhc_stream_if
`default_nettype wire

/* File: design/nhc_skid_buffer.sv */
`default_nettype none
module nhc_skid_buffer
   import nhc_pkg::*;
#(
   parameter int DEPTH = 2
)
(
   input wire logic clk,
   input wire logic rst_n,
   nhc_stream_if.dst in_s,
   nhc_stream_if.src out_s
);
   initial
   begin
      if (DEPTH != 2)
         $error("depth must be 2");
   end
   logic [7:0] mem_reg [DEPTH];
   logic [1:0] count_reg;
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   wire push = in_s.valid && in_s.ready;
   wire pop = out_s.valid && out_s.ready;
   assign in_s.ready = (count_reg != 2'h2);
   assign out_s.valid = (count_reg != 2'h0);
   assign out_s.data = mem_reg[rd_ptr_reg];
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_reg <= 2'h0;
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         mem_reg[0] <= 8'h00;
         mem_reg[1] <= 8'h00;
      end
      else
      begin
         if (push)
         begin
            mem_reg[wr_ptr_reg] <= in_s.data;
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop)
            rd_ptr_reg <= ~rd_ptr_reg;
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end
   a_buf_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
      count_reg == 2'h2 |-> !in_s.ready)
      else $error("buffer accepts when full");
endmodule : nhc_skid_buffer
`default_nettype wire

/* File: design/nhc_bus_cycle.sv */
`default_nettype none
module nhc_bus_cycle
   import nhc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start_write,
   input wire logic start_read,
   input wire logic [7:0] wr_byte,
   input wire logic [7:0] bus_in_sync,
   output logic busy,
   output logic we_n,
   output logic re_n,
   output logic [7:0] bus_out,
   output logic bus_oe,
   output logic rd_done,
   output logic [7:0] rd_byte
);
   nhc_bus_state_t state_reg;
   logic [3:0] cnt_reg;
   logic [7:0] out_reg;
   logic [7:0] rd_reg;
   logic done_reg;
   wire cnt_zero = (cnt_reg == 4'h0);
   assign busy = (state_reg != BUS_IDLE);
   assign we_n = (state_reg != BUS_WE_LOW);
   assign re_n = (state_reg != BUS_RE_LOW);
   assign bus_oe = (state_reg == BUS_WE_LOW) || (state_reg == BUS_WE_HIGH);
   assign bus_out = out_reg;
   assign rd_done = done_reg;
   assign rd_byte = rd_reg;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= BUS_IDLE;
         cnt_reg <= 4'h0;
         out_reg <= 8'h00;
         rd_reg <= 8'h00;
         done_reg <= 1'b0;
      end
      else
      begin
         done_reg <= 1'b0;
         if (!cnt_zero)
            cnt_reg <= cnt_reg - 4'h1;
         unique case (state_reg)
            BUS_IDLE:
            begin
               if (start_write)
               begin
                  out_reg <= wr_byte;
                  cnt_reg <= 4'(STROBE_LOW_CYC - 1);
                  state_reg <= BUS_WE_LOW;
               end
               else if (start_read)
               begin
                  cnt_reg <= 4'(STROBE_LOW_CYC - 1);
                  state_reg <= BUS_RE_LOW;
               end
            end
            BUS_WE_LOW:
               if (cnt_zero)
               begin
                  cnt_reg <= 4'(STROBE_HIGH_CYC - 1);
                  state_reg <= BUS_WE_HIGH;
               end
            BUS_WE_HIGH:
               if (cnt_zero)
                  state_reg <= BUS_IDLE;
            BUS_RE_LOW:
               if (cnt_zero)
               begin
                  // hold capture until the byte has crossed both sync flops
                  cnt_reg <= 4'(STROBE_HIGH_CYC + SYNC_STAGES - 2);
                  state_reg <= BUS_RE_HIGH;
               end
            BUS_RE_HIGH:
               if (cnt_zero)
               begin
                  rd_reg <= bus_in_sync;
                  done_reg <= 1'b1;
                  state_reg <= BUS_IDLE;
               end
         endcase
      end
   end
endmodule : nhc_bus_cycle
`default_nettype wire

/* File: design/nhc_host.sv */
`default_nettype none
// What this block does
// - send four address bytes: column low, column high nibble, two row bytes
// - drive upper four bus lines low in the second address cycle
// - read data only with both latch enables low, chip select low, we high
// - page read is 00h, four address cycles, then 30h; OP_FIRST_READ omits the 00h and starts at the first address cycle
// - after a status read, resend 00h before reading page data (not enforced: OP_FIRST_READ and OP_READ_BYTES send no 00h)
// - column move is 05h, two column address cycles, then E0h
// - column moves may repeat but stay within the loaded page
// - random input and output commands used only within one page
// - only codes of the defined command set are ever sent
// - id read is 90h, address 00h, then five strobed bytes
module nhc_host
   import nhc_pkg::*;
#(
   parameter int LEN_W = 12
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [3:0] req_op,
   input wire logic [11:0] req_column,
   input wire logic [15:0] req_row,
   input wire logic [LEN_W-1:0] req_len,
   output logic rsp_valid,
   input wire logic rsp_ready,
   output logic [7:0] rsp_data,
   output logic done,
   output logic ce_n,
   output logic cle,
   output logic ale,
   output logic we_n,
   output logic read_strobe_n,
   output logic write_protect_n,
   input wire logic ready_busy_n,
   input wire logic [7:0] bus_in,
   output logic [7:0] bus_out,
   output logic bus_oe
);
   initial
   begin
      if (LEN_W < 3 || LEN_W > 16)
         $error("LEN_W out of range");
   end
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_SEND = 3'b001,
      ST_WAIT = 3'b010,
      ST_READ = 3'b011,
      ST_DONE = 3'b100
   } nhc_state_t;
   typedef enum logic [1:0]
   {
      K_CMD = 2'b00,
      K_ADDR = 2'b01,
      K_END = 2'b10
   } nhc_kind_t;

   logic rst_s1_reg;
   logic rst_n_reg;
   logic [7:0] bus_s1_reg;
   logic [7:0] bus_s2_reg;
   logic rb_s1_reg;
   logic rb_s2_reg;
   nhc_state_t state_reg;
   logic [3:0] op_reg;
   logic [11:0] col_reg;
   logic [15:0] row_reg;
   logic [LEN_W-1:0] left_reg;
   logic [2:0] step_reg;
   logic cle_reg;
   logic ale_reg;
   logic done_reg;
   logic rd_pending_reg;

   nhc_stream_if fill_s ();
   nhc_stream_if drain_s ();

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_s1_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_n_reg <= rst_s1_reg;
      end
   end

   always_ff @(posedge clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         bus_s1_reg <= 8'h00;
         bus_s2_reg <= 8'h00;
         rb_s1_reg <= 1'b0;
         rb_s2_reg <= 1'b0;
      end
      else
      begin
         bus_s1_reg <= bus_in;
         bus_s2_reg <= bus_s1_reg;
         rb_s1_reg <= ready_busy_n;
         rb_s2_reg <= rb_s1_reg;
      end
   end

   // byte and latch kind for each step of each operation
   function automatic logic [9:0] seq_item(input logic [3:0] op,
      input logic [2:0] step, input logic [11:0] col,
      input logic [15:0] row);
      logic [9:0] r;
      r = {K_END, 8'h00};
      unique case (op)
         OP_PAGE_READ, OP_FIRST_READ:
         begin
            logic [2:0] s;
            s = (op == OP_FIRST_READ) ? step + 3'h1 : step;
            unique case (s)
               3'h0: r = {K_CMD, CMD_READ_SETUP};
               3'h1: r = {K_ADDR, col[7:0]};
               3'h2: r = {K_ADDR, BUS_HIGH_NIBBLE_LOW, col[11:8]};
               3'h3: r = {K_ADDR, row[7:0]};
               3'h4: r = {K_ADDR, row[15:8]};
               3'h5: r = {K_CMD, CMD_READ_CONFIRM};
               default: r = {K_END, 8'h00};
            endcase
         end
         OP_COL_MOVE:
            unique case (step)
               3'h0: r = {K_CMD, CMD_COL_SETUP};
               3'h1: r = {K_ADDR, col[7:0]};
               3'h2: r = {K_ADDR, BUS_HIGH_NIBBLE_LOW, col[11:8]};
               3'h3: r = {K_CMD, CMD_COL_CONFIRM};
               default: r = {K_END, 8'h00};
            endcase
         OP_READ_ID, OP_SIGNATURE:
            unique case (step)
               3'h0: r = {K_CMD, CMD_READ_ID};
               3'h1: r = {K_ADDR, (op == OP_SIGNATURE) ?
                  ID_ADDR_SIGNATURE : ID_ADDR_DEVICE};
               default: r = {K_END, 8'h00};
            endcase
         OP_STATUS:
            r = (step == 3'h0) ? {K_CMD, CMD_STATUS} : {K_END, 8'h00};
         default: r = {K_END, 8'h00};
      endcase
      return r;
   endfunction : seq_item

   wire [9:0] item = seq_item(op_reg, step_reg, col_reg, row_reg);
   wire [1:0] item_kind = item[9:8];
   wire [7:0] item_byte = item[7:0];
   wire op_known = (req_op <= OP_FIRST_READ);
   wire cyc_busy;
   wire cyc_done;
   wire [7:0] cyc_byte;
   wire start_write = (state_reg == ST_SEND) && !cyc_busy &&
      (item_kind != K_END);
   wire start_read = (state_reg == ST_READ) && !cyc_busy &&
      !rd_pending_reg && (left_reg != '0) && fill_s.ready;
   wire [LEN_W-1:0] id_len = (req_op == OP_SIGNATURE) ?
      LEN_W'(ID_SIGNATURE_BYTES) : LEN_W'(ID_DEVICE_BYTES);

   nhc_bus_cycle u_cycle
   (
      .clk(clk),
      .rst_n(rst_n_reg),
      .start_write(start_write),
      .start_read(start_read),
      .wr_byte(item_byte),
      .bus_in_sync(bus_s2_reg),
      .busy(cyc_busy),
      .we_n(we_n),
      .re_n(read_strobe_n),
      .bus_out(bus_out),
      .bus_oe(bus_oe),
      .rd_done(cyc_done),
      .rd_byte(cyc_byte)
   );

   assign fill_s.valid = cyc_done;
   assign fill_s.data = cyc_byte;
   nhc_skid_buffer #(.DEPTH(2)) u_buf
   (
      .clk(clk),
      .rst_n(rst_n_reg),
      .in_s(fill_s),
      .out_s(drain_s)
   );
   assign rsp_valid = drain_s.valid;
   assign rsp_data = drain_s.data;
   assign drain_s.ready = rsp_ready;

   assign req_ready = (state_reg == ST_IDLE);
   assign ce_n = 1'b0;
   assign cle = cle_reg;
   assign ale = ale_reg;
   assign write_protect_n = 1'b0;
   assign done = done_reg;

   always_ff @(posedge clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         state_reg <= ST_IDLE;
         op_reg <= OP_PAGE_READ;
         col_reg <= 12'h000;
         row_reg <= 16'h0000;
         left_reg <= '0;
         step_reg <= 3'h0;
         cle_reg <= 1'b0;
         ale_reg <= 1'b0;
         done_reg <= 1'b0;
         rd_pending_reg <= 1'b0;
      end
      else
      begin
         done_reg <= 1'b0;
         if (start_read)
            rd_pending_reg <= 1'b1;
         else if (cyc_done)
            rd_pending_reg <= 1'b0;
         unique case (state_reg)
            ST_IDLE:
               if (req_valid && op_known)
               begin
                  op_reg <= req_op;
                  col_reg <= req_column;
                  row_reg <= req_row;
                  step_reg <= 3'h0;
                  left_reg <= (req_op == OP_READ_ID ||
                     req_op == OP_SIGNATURE) ? id_len : req_len;
                  state_reg <= (req_op == OP_READ_BYTES) ? ST_READ : ST_SEND;
               end
            ST_SEND:
               if (start_write)
               begin
                  cle_reg <= (item_kind == K_CMD);
                  ale_reg <= (item_kind == K_ADDR);
                  step_reg <= step_reg + 3'h1;
               end
               else if (!cyc_busy && item_kind == K_END)
               begin
                  cle_reg <= 1'b0;
                  ale_reg <= 1'b0;
                  if (op_reg == OP_PAGE_READ || op_reg == OP_FIRST_READ)
                     state_reg <= ST_WAIT;
                  else if (op_reg == OP_STATUS || op_reg == OP_COL_MOVE)
                     state_reg <= ST_READ;
                  else
                     state_reg <= ST_READ;
               end
            ST_WAIT:
               if (rb_s2_reg)
                  state_reg <= ST_READ;
            ST_READ:
            begin
               if (start_read)
                  left_reg <= left_reg - LEN_W'(1);
               if (left_reg == '0 && !cyc_busy && !rd_pending_reg)
                  state_reg <= ST_DONE;
            end
            ST_DONE:
            begin
               done_reg <= 1'b1;
               state_reg <= ST_IDLE;
            end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

   a_addr_nibble_low: assert property (@(posedge clk) disable iff (!rst_n_reg)
      start_write && item_kind == K_ADDR && step_reg == 3'h2 &&
      op_reg == OP_COL_MOVE |-> item_byte[7:4] == 4'h0)
      else $error("high nibble not low in second address cycle");
   a_read_latch_low: assert property (@(posedge clk) disable iff (!rst_n_reg)
      !read_strobe_n |-> !cle && !ale && we_n)
      else $error("read strobe with latch enable or write strobe");
   a_wait_ready: assert property (@(posedge clk) disable iff (!rst_n_reg)
      state_reg == ST_WAIT && !rb_s2_reg |=> state_reg == ST_WAIT)
      else $error("left wait while busy");
   a_cmd_latch: assert property (@(posedge clk) disable iff (!rst_n_reg)
      $rose(we_n) |-> !(cle && ale))
      else $error("both latch enables high at strobe rise");
   a_write_oe: assert property (@(posedge clk) disable iff (!rst_n_reg)
      !we_n |-> bus_oe)
      else $error("write strobe without bus drive");
   a_no_overread: assert property (@(posedge clk) disable iff (!rst_n_reg)
      $fell(read_strobe_n) |-> $past(left_reg) != '0)
      else $error("strobe beyond requested length");
   a_first_cmd: assert property (@(posedge clk) disable iff (!rst_n_reg)
      start_write && step_reg == 3'h0 && op_reg == OP_PAGE_READ
      |-> item_byte == CMD_READ_SETUP)
      else $error("page read not opened with setup byte");
   a_oe_off_read: assert property (@(posedge clk) disable iff (!rst_n_reg)
      !read_strobe_n |-> !bus_oe)
      else $error("bus driven during read strobe");
   c_page_read: cover property (@(posedge clk) disable iff (!rst_n_reg)
      state_reg == ST_WAIT ##[1:300] state_reg == ST_READ);
   c_id_read: cover property (@(posedge clk) disable iff (!rst_n_reg)
      op_reg == OP_READ_ID && done_reg);
   c_stall: cover property (@(posedge clk) disable iff (!rst_n_reg)
      rsp_valid && !rsp_ready && !fill_s.ready);
endmodule : nhc_host
`default_nettype wire

/* File: verif/nhc_nand_model.sv */
`default_nettype none
module nhc_nand_model
   import nhc_pkg::*;
#(
   parameter int LOAD_CYC = 20,
   parameter logic [7:0] MAKER_CODE = 8'hA7, // arbitrary value
   parameter logic [7:0] PART_CODE = 8'h3B, // arbitrary value
   parameter logic [7:0] STATUS_BYTE = 8'hE0
)
(
   input wire logic clk,
   input wire logic ce_n,
   input wire logic cle,
   input wire logic ale,
   input wire logic we_n,
   input wire logic read_strobe_n,
   input wire logic write_protect_n,
   input wire logic [7:0] host_bus,
   input wire logic host_oe,
   output logic ready_busy_n,
   output logic [7:0] bus_to_host
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cmd_reg = 8'h00;
   logic [11:0] col = 12'h000;
   logic [15:0] row = 16'h0000;
   logic [7:0] dout = 8'h00;
   logic [7:0] id_tab [5];
   logic [7:0] sig_tab [4];
   int acnt = 0;
   int busy_cnt = 0;
   int idx = 0;
   int mode = 0;
   int err_cnt = 0;
   wire out_sel = !ce_n && !cle && !ale && we_n;
   assign id_tab = '{MAKER_CODE, PART_CODE, 8'h00, 8'h95, 8'h00};
   assign sig_tab = '{8'h4F, 8'h4E, 8'h46, 8'h49};
   assign ready_busy_n = (busy_cnt == 0);
   assign bus_to_host = host_oe ? host_bus : (out_sel ? dout : ~dout);
   function automatic logic [7:0] pg(input logic [11:0] c,
      input logic [15:0] r);
      return c[7:0] ^ r[7:0] ^ {r[15:12], c[11:8]};
   endfunction : pg
   always @(posedge clk)
   begin
      if (busy_cnt > 0)
         busy_cnt--;
   end
   always @(posedge we_n)
   begin
      if (!ce_n && cle)
      begin
         cmd_reg = host_bus;
         acnt = 0;
         case (host_bus)
            8'h30: begin busy_cnt = LOAD_CYC; mode = 0; end
            8'h70: mode = 3;
            8'hE0: mode = 0;
            8'h00, 8'h05, 8'h90: idx = 0;
            default: err_cnt++;
         endcase
      end
      else if (!ce_n && ale)
      begin
         if (cmd_reg == 8'h90 && acnt == 0)
            mode = (host_bus == 8'h20) ? 2 : 1;
         else if (acnt < ((cmd_reg == 8'h05) ? 2 : 4))
            case (acnt)
               0: col[7:0] = host_bus;
               1: begin
                     col[11:8] = host_bus[3:0];
                     if (host_bus[7:4] != 4'h0)
                        err_cnt++;
                  end
               2: row[7:0] = host_bus;
               default: row[15:8] = host_bus;
            endcase
         acnt++;
      end
   end
   always @(negedge read_strobe_n)
   begin
      if (out_sel)
      begin
         if (busy_cnt > 0)
            err_cnt++;
         case (mode)
            0: begin
                  if (col > 12'h83F)
                     err_cnt++;
                  dout = pg(col, row);
                  col++;
               end
            1: dout = (idx < 5) ? id_tab[idx] : 8'h00;
            2: dout = (idx < 4) ? sig_tab[idx] : 8'h00;
            default: dout = STATUS_BYTE;
         endcase
         idx++;
      end
   end
endmodule : nhc_nand_model
`default_nettype wire

/* File: verif/testbench.sv */
`default_nettype none
module testbench
   import nhc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] MAKER = 8'hA7; // arbitrary value
   localparam logic [7:0] PART = 8'h3B; // arbitrary value
   localparam logic [7:0] STAT = 8'hE0;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic req_valid = 1'b0;
   logic req_ready;
   logic [3:0] req_op = 4'h0;
   logic [11:0] req_column = 12'h000;
   logic [15:0] req_row = 16'h0000;
   logic [11:0] req_len = 12'h000;
   logic rsp_valid;
   logic rsp_ready = 1'b1;
   logic [7:0] rsp_data;
   logic done, ce_n, cle, ale, we_n, read_strobe_n, write_protect_n;
   logic ready_busy_n, bus_oe;
   logic [7:0] bus_in, bus_out;
   logic [7:0] got [$];
   logic busy_seen;
   int n_errors = 0;
   int tests_run = 0;
   always #50 clk = ~clk;
   nhc_host dut_u (.clk(clk), .resetn(resetn), .req_valid(req_valid),
      .req_ready(req_ready), .req_op(req_op), .req_column(req_column),
      .req_row(req_row), .req_len(req_len), .rsp_valid(rsp_valid),
      .rsp_ready(rsp_ready), .rsp_data(rsp_data), .done(done),
      .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
      .read_strobe_n(read_strobe_n), .write_protect_n(write_protect_n),
      .ready_busy_n(ready_busy_n), .bus_in(bus_in), .bus_out(bus_out),
      .bus_oe(bus_oe));
   nhc_nand_model #(.LOAD_CYC(20), .MAKER_CODE(MAKER), .PART_CODE(PART),
      .STATUS_BYTE(STAT)) model_u (.clk(clk), .ce_n(ce_n), .cle(cle),
      .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n),
      .write_protect_n(write_protect_n), .host_bus(bus_out),
      .host_oe(bus_oe), .ready_busy_n(ready_busy_n), .bus_to_host(bus_in));
   function automatic logic [7:0] pg(input logic [11:0] c,
      input logic [15:0] r);
      return c[7:0] ^ r[7:0] ^ {r[15:12], c[11:8]};
   endfunction : pg
   task automatic check(input logic [15:0] seen, input logic [15:0] expv);
      tests_run++;
      if (seen !== expv)
      begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
            expv);
      end
   endtask : check
   task automatic close_out();
      if (n_errors == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out
   task automatic run_op(input logic [3:0] op, input logic [11:0] c,
      input logic [15:0] r, input int len, input bit stall);
      bit taken;
      bit seen;
      int t;
      got.delete();
      taken = 0;
      seen = 0;
      busy_seen = 0;
      @(posedge clk);
      #1;
      req_op = op;
      req_column = c;
      req_row = r;
      req_len = len[11:0];
      req_valid = 1'b1;
      rsp_ready = !stall;
      for (t = 0; t < 3000 && !(taken && seen && got.size() == len); t++)
      begin
         @(posedge clk);
         if (req_valid && req_ready === 1'b1)
            taken = 1;
         if (rsp_valid === 1'b1 && rsp_ready)
            got.push_back(rsp_data);
         if (done === 1'b1)
            seen = 1;
         if (ready_busy_n === 1'b0)
            busy_seen = 1;
         #1;
         if (taken)
            req_valid = 1'b0;
         if (t == 100)
            rsp_ready = 1'b1;
      end
      check({15'h0, seen}, 16'h0001);
      check(got.size(), len);
   endtask : run_op
   task automatic verify_page(input logic [11:0] c, input logic [15:0] r);
      foreach (got[i])
         check(got[i], pg(c + i, r));
   endtask : verify_page
   task automatic t_first_read();
      run_op(OP_FIRST_READ, 12'h010, 16'h1234, 4, 0);
      verify_page(12'h010, 16'h1234);
   endtask : t_first_read
   task automatic t_page_stall();
      run_op(OP_PAGE_READ, 12'h83A, 16'h5A21, 6, 1);
      verify_page(12'h83A, 16'h5A21);
      check(busy_seen, 1'b1);
   endtask : t_page_stall
   task automatic t_col_move();
      run_op(OP_COL_MOVE, 12'h123, 16'h0000, 3, 0);
      verify_page(12'h123, 16'h5A21);
      run_op(OP_READ_BYTES, 12'h000, 16'h0000, 2, 0);
      verify_page(12'h126, 16'h5A21);
   endtask : t_col_move
   task automatic t_ident();
      logic [7:0] exp_id [5];
      logic [7:0] exp_sig [4];
      exp_id = '{MAKER, PART, 8'h00, 8'h95, 8'h00};
      exp_sig = '{8'h4F, 8'h4E, 8'h46, 8'h49};
      run_op(OP_READ_ID, 12'h000, 16'h0000, 5, 0);
      foreach (got[i])
         check(got[i], exp_id[i]);
      run_op(OP_SIGNATURE, 12'h000, 16'h0000, 4, 0);
      foreach (got[i])
         check(got[i], exp_sig[i]);
   endtask : t_ident
   task automatic t_status();
      run_op(OP_STATUS, 12'h000, 16'h0000, 2, 0);
      foreach (got[i])
         check(got[i], STAT);
      run_op(OP_PAGE_READ, 12'h040, 16'h0777, 3, 0);
      verify_page(12'h040, 16'h0777);
   endtask : t_status
   initial
   begin
      #(20000 * 100);
      n_errors++;
      close_out();
   end
   initial
   begin
      repeat (6) @(posedge clk);
      #1;
      resetn = 1'b1;
      repeat (3) @(posedge clk);
      t_first_read();
      t_page_stall();
      t_col_move();
      t_ident();
      t_status();
      check(write_protect_n, 1'b0);
      check(ce_n, 1'b0);
      check(model_u.err_cnt, 0);
      close_out();
   end
endmodule : testbench
`default_nettype wire
